// >>> bench/host_link.sv
// Host model driving frames on the three-wire serial link
`default_nettype none
module host_link;
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk = 1'b1;
    logic sync_n = 1'b1;
    logic din = 1'b0;
    // Sends n bits MSB first; clock stands high outside frames
    task automatic send(input logic [15:0] w, input int n, input logic en);
        sync_n = ~en;
        #17;
        for (int i = 15; i > 15 - n; i--) begin
            din = w[i];
            sclk = 1'b1;
            #17;
            sclk = 1'b0;
            #17;
        end
        sclk = 1'b1;
        #17;
        sync_n = 1'b1;
        din = ~din; // Released line shows no stale bit
        #40;
    endtask : send
endmodule : host_link
`default_nettype wire

// >>> bench/serial_dac_input_port_test.sv
// Testbench: frames, aborts and modes against a reference model
`default_nettype none
module serial_dac_input_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] analog_output;
    logic powered_down;
    logic update_pulse;
    int n_mismatch = 0;
    int num_checks = 0;
    int pulses = 0;
    int seed = 49087;
    int exp_code = 0;
    int exp_pd = 0;
    int exp_pulses = 0;
    logic [15:0] w;
    host_link u_host();
    serial_dac_input_port u_dut(
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .sclk(u_host.sclk),
        .sync_n(u_host.sync_n),
        .din(u_host.din),
        .analog_output(analog_output),
        .powered_down(powered_down),
        .update_pulse(update_pulse)
    );
    always #2.5 ref_clk = ~ref_clk;
    // Counts accepted-frame pulses
    always @(posedge ref_clk) if (update_pulse === 1'b1) pulses++;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // One frame, then model update and comparison
    task automatic frame(input logic [15:0] fw, input int n, input logic en);
        u_host.send(fw, n, en);
        repeat (10) @(posedge ref_clk);
        if (en && n == 16) begin
            exp_pd = (fw[15:12] != 4'h0);
            exp_code = exp_pd ? 0 : int'(fw[11:0]);
            exp_pulses++;
        end
        check({4'h0, analog_output}, 16'(exp_code));
        check({15'h0, powered_down}, 16'(exp_pd));
        check(16'(pulses), 16'(exp_pulses));
    endtask : frame
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check({4'h0, analog_output}, 16'h0000);
        frame(16'h0ABC, 12, 1'b1);
        frame(16'h0123, 16, 1'b0);
        frame(16'h0FFF, 16, 1'b1);
        for (int m = 0; m < 16; m++) begin
            w = 16'($random(seed));
            w[15:12] = 4'(m);
            frame(w, 16, 1'b1);
            frame(~w, 15, 1'b1);
        end
        // Mid-run reset returns the output to zero
        frame(16'h0A5A, 16, 1'b1);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({4'h0, analog_output}, 16'h0000);
        reset_n <= 1'b1;
        exp_code = 0;
        exp_pd = 0;
        repeat (5) @(posedge ref_clk);
        check({15'h0, powered_down}, 16'h0000);
        frame(16'h0321, 16, 1'b1);
        summarize();
    end
    // Watchdog
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule : serial_dac_input_port_test
`default_nettype wire

// >>> hdl/frame_capture.sv
// Link-side shift register: captures 16-bit frames on falling serial clock
`default_nettype none
module frame_capture (
    input wire logic sclk,
    input wire logic rst_n,
    input wire logic sync_n,
    input wire logic din,
    output serial_dac_pkg::frame_word_t frame_out,
    output logic frame_toggle
);
    logic [14:0] shift_reg;
    logic [4:0] count_reg;

    // Shift on falling edge, async clear while sync high aborts frame
    always_ff @(negedge sclk or posedge sync_n) begin
        if (sync_n) begin
            shift_reg <= 15'h0000;
            count_reg <= 5'h00;
        end else begin
            shift_reg <= {shift_reg[13:0], din};
            count_reg <= count_reg + 5'h01;
        end
    end

    // Sixteenth edge latches full frame and flags it by toggle
    // Toggle survives frame sync high so the core never loses a frame
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_toggle <= 1'b0;
            frame_out <= '0;
        end else if (!sync_n
            && count_reg == 5'(serial_dac_pkg::FRAME_BITS - 1)) begin
            frame_out <= {shift_reg, din};
            frame_toggle <= ~frame_toggle;
        end
    end
endmodule : frame_capture
`default_nettype wire

// >>> hdl/serial_dac_input_port.sv
// Top: serial input port and output update control for a 12-bit converter
`default_nettype none
module serial_dac_input_port (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic din,
    output logic [11:0] analog_output,
    output logic powered_down,
    output logic update_pulse
);
    // ******************************
    // Reset release
    // ******************************
    logic rst_s1_reg;
    logic rst_n_reg;

    // Two-stage release of asynchronous reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // ******************************
    // Link domain capture
    // ******************************
    serial_dac_pkg::frame_word_t link_frame;
    logic link_toggle;

    frame_capture u_capture (
        .sclk(sclk),
        .rst_n(rst_n_reg),
        .sync_n(sync_n),
        .din(din),
        .frame_out(link_frame),
        .frame_toggle(link_toggle)
    );

    // ******************************
    // Crossing into core domain
    // ******************************
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic take;

    // Toggle synchroniser; frame word is stable long before toggle lands
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end else begin
            tog_s1_reg <= link_toggle;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end

    assign take = tog_s2_reg ^ tog_s3_reg;

    // ******************************
    // Output state
    // ******************************
    serial_dac_pkg::analog_state_t state_reg;

    // Update output only on completed frames; reset holds zero
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg.code <= serial_dac_pkg::CODE_RESET;
            state_reg.powered_down <= 1'b0;
        end else if (take) begin
            state_reg.code <= link_frame.code;
            state_reg.powered_down <=
                (link_frame.mode != serial_dac_pkg::MODE_NORMAL);
        end
    end

    // Update strobe, one core cycle per accepted frame
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            update_pulse <= 1'b0;
        end else begin
            update_pulse <= take;
        end
    end

    // Output level register; power-down parks it at zero
    logic [11:0] level_reg;

    // Output level follows each accepted frame
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            level_reg <= serial_dac_pkg::CODE_RESET;
        end else if (take) begin
            if (link_frame.mode != serial_dac_pkg::MODE_NORMAL) begin
                level_reg <= 12'h000;
            end else begin
                level_reg <= link_frame.code;
            end
        end
    end

    // Outputs straight from flops
    assign analog_output = level_reg;
    assign powered_down = state_reg.powered_down;

    // ******************************
    // Write history
    // ******************************
    logic frame_seen_reg;

    // Set by the first accepted frame since reset
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            frame_seen_reg <= 1'b0;
        end else if (take) begin
            frame_seen_reg <= 1'b1;
        end
    end

    // ******************************
    // Frame sync seen from core
    // ******************************
    // Idle cycles after which a late take is impossible
    localparam logic [2:0] IDLE_SETTLE = 3'h3;
    logic sync_s1_reg;
    logic sync_s2_reg;
    logic [2:0] idle_cnt_reg;

    // Two flops; reset to idle level so no false edge follows reset
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sync_s1_reg <= 1'b1;
            sync_s2_reg <= 1'b1;
        end else begin
            sync_s1_reg <= sync_n;
            sync_s2_reg <= sync_s1_reg;
        end
    end

    // Saturating count of core cycles with frame sync idle
    always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            idle_cnt_reg <= 3'h0;
        end else if (!sync_s2_reg) begin
            idle_cnt_reg <= 3'h0;
        end else if (idle_cnt_reg != 3'h7) begin
            idle_cnt_reg <= idle_cnt_reg + 3'h1;
        end
    end

    // ******************************
    // Checks
    // ******************************
    // Reset forces zero code, normal mode, no strobe
    a_reset_zero_out: assert property (@(posedge ref_clk)
        !rst_n_reg |-> analog_output == 12'h000 && !powered_down
            && !update_pulse)
        else $error("output not zero in reset");

    // No level but zero before the first accepted frame
    a_zero_until_frame: assert property (@(posedge ref_clk)
        !frame_seen_reg |-> analog_output == 12'h000 && !powered_down)
        else $error("output moved before first frame");

    // ******************************
    // Checks: update path
    // ******************************
    // Output state and level hold between accepted frames
    a_hold_no_take: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg) !take |=> $stable(state_reg)
            && $stable(level_reg))
        else $error("output changed without frame");

    // Each take lands the frame and raises the strobe
    a_update_on_take: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg) take |=> update_pulse
            && state_reg.code == $past(link_frame.code))
        else $error("frame not applied");

    // Strobe lasts a single core cycle
    a_pulse_width: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg) update_pulse |=> !update_pulse)
        else $error("update pulse too long");

    // Frame word has settled by the time the toggle lands
    a_frame_stable: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg) take |-> $stable(link_frame))
        else $error("frame word moved at crossing");

    // Normal mode shows the full written code
    a_code_width: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg) !powered_down
            |-> analog_output == state_reg.code)
        else $error("code path wrong");

    // ******************************
    // Checks: power-down
    // ******************************
    // Nonzero mode parks the output at zero
    a_pd_mode: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg)
            take && link_frame.mode != serial_dac_pkg::MODE_NORMAL
            |=> powered_down && analog_output == 12'h000)
        else $error("power-down not entered");

    // Normal mode frame wakes the output
    a_pd_exit: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg)
            take && link_frame.mode == serial_dac_pkg::MODE_NORMAL
            |=> !powered_down)
        else $error("normal mode not restored");

    // ******************************
    // Checks: frame sync
    // ******************************
    // No toggle from clocks that arrive with frame sync high
    a_idle_ignored: assert property (@(negedge sclk)
        disable iff (!rst_n_reg) sync_n |=> $stable(link_toggle))
        else $error("bits taken while frame sync high");

    // Long idle frame sync never yields a take
    a_idle_no_take: assert property (@(posedge ref_clk)
        disable iff (!rst_n_reg) idle_cnt_reg >= IDLE_SETTLE |-> !take)
        else $error("take without a complete frame");

    // ******************************
    // Coverage
    // ******************************
    // Update, power-down in and out, two updates, full scale
    c_update: cover property (@(posedge ref_clk) update_pulse);
    c_power_down: cover property (@(posedge ref_clk) $rose(powered_down));
    c_power_up: cover property (@(posedge ref_clk) $fell(powered_down));
    c_two_updates: cover property (@(posedge ref_clk)
        update_pulse ##[1:200] update_pulse);
    c_full_scale: cover property (@(posedge ref_clk)
        update_pulse && analog_output == 12'hFFF);
endmodule : serial_dac_input_port
`default_nettype wire

// >>> hdl/serial_dac_pkg.sv
// Package: constants and carrier types for the serial converter input port
`default_nettype none
package serial_dac_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int MODE_LSB = 12;
    localparam int MODE_BITS = 4;
    localparam int COUNT_BITS = 5;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_RESET = 4'h0;
    // Serial clock limit that the host keeps, in MHz
    localparam int SCLK_MAX_MHZ = 30;

    // One accepted frame, handed from link domain to core domain
    typedef struct packed {
        logic [3:0] mode;
        logic [11:0] code;
    } frame_word_t;

    // Converter output state
    typedef struct packed {
        logic powered_down;
        logic [11:0] code;
    } analog_state_t;
endpackage : serial_dac_pkg
`default_nettype wire
